// [design/smb_mr3_burst_top.sv]
`timescale 1ns/1ns
module smb_mr3_burst_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] temp_code_i,
  output logic readout_en_o,
  output logic [1:0] readout_loc_o,
  output logic int_write_start_o,
  input wire logic ck_i,
  input wire smb_pkg::smb_cmd_t cmd_i,
  input wire logic [7:0] dq_i,
  output logic [7:0] dq_o,
  output logic dq_oe_o,
  output logic dqs_o,
  output logic dqs_oe_o
);
  import smb_pkg::*;

  // link clock domain
  logic lrst;
  logic [14:0] readout_control_mode_reg_ff;
  logic [14:0] primary_mode_reg_ff;
  smb_state_t state_ff;
  logic [3:0] cnt_ff;
  logic [2:0] beat_ff;
  logic is_wr_ff;
  logic chop_ff;
  logic fixchop_ff;
  logic [2:0] start_ff;
  logic [2:0] base_ff;
  logic [7:0] mem [64];
  logic [7:0] temp_lnk_ff;
  logic ack_ff;
  logic req_s;
  logic wr_tgl_ff;
  logic [2:0] col;
  logic [7:0] rd_data;
  logic [7:0] mem_rd;
  logic is_mrs;
  logic is_rd;
  logic is_wr;
  logic multi_purpose_readout_enable;
  logic [1:0] readout_location_select;
  logic fixed_chop4_mode;
  logic on_the_fly_chop4_mode;
  logic in_burst;
  logic beat_live;

  // core clock domain
  logic req_ff;
  logic [7:0] temp_hold_ff;
  logic ack_s;
  logic wr_tgl_s;
  logic wr_tgl_seen_ff;
  smb_status_t status_s;
  smb_status_t status_prev_ff;

  smb_sync #(.W(1)) u_lrst (
    .clk_i(ck_i),
    .rst_i(1'b0),
    .d_i(rst_i),
    .q_o(lrst)
  );

  assign is_mrs = ~cmd_i.cs_n & ~cmd_i.ras_n & ~cmd_i.cas_n & ~cmd_i.we_n;
  assign is_rd = ~cmd_i.cs_n & cmd_i.ras_n & ~cmd_i.cas_n & cmd_i.we_n;
  assign is_wr = ~cmd_i.cs_n & cmd_i.ras_n & ~cmd_i.cas_n & ~cmd_i.we_n;
  assign multi_purpose_readout_enable = readout_control_mode_reg_ff[RO_EN_BIT];
  assign readout_location_select = readout_control_mode_reg_ff[LOC_LSB +: 2];
  assign fixed_chop4_mode = primary_mode_reg_ff[BL_LSB +: 2] == BL_FIXED4;
  assign on_the_fly_chop4_mode = primary_mode_reg_ff[BL_LSB +: 2] == BL_OTF;
  assign in_burst = state_ff == ST_BURST;
  assign beat_live = in_burst & (~chop_ff | ~beat_ff[2]);

  // mode register set; address bits stored whole, upper bits kept as written
  always_ff @(posedge ck_i) begin
    if (lrst) begin
      readout_control_mode_reg_ff <= MR_RESET;
      primary_mode_reg_ff <= MR_RESET;
    end else if (is_mrs && cmd_i.ba == BA_READOUT) begin
      readout_control_mode_reg_ff <= cmd_i.addr;
    end else if (is_mrs && cmd_i.ba == BA_PRIMARY) begin
      primary_mode_reg_ff <= cmd_i.addr;
    end
  end

  // burst engine; commands arriving while busy are dropped
  always_ff @(posedge ck_i) begin
    if (lrst) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 4'h0;
      beat_ff <= 3'h0;
      is_wr_ff <= 1'b0;
      chop_ff <= 1'b0;
      fixchop_ff <= 1'b0;
      start_ff <= 3'h0;
      base_ff <= 3'h0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (is_rd || is_wr) begin
            state_ff <= ST_WAIT;
            cnt_ff <= WAIT_LOAD;
            beat_ff <= 3'h0;
            is_wr_ff <= is_wr;
            start_ff <= cmd_i.addr[2:0];
            base_ff <= cmd_i.addr[5:3];
            fixchop_ff <= fixed_chop4_mode;
            chop_ff <= fixed_chop4_mode
              | (on_the_fly_chop4_mode & ~cmd_i.addr[CHOP_PIN_BIT]);
          end
        end
        ST_WAIT: begin
          if (cnt_ff == 4'h0) begin
            state_ff <= ST_BURST;
          end else begin
            cnt_ff <= cnt_ff - 4'h1;
          end
        end
        ST_BURST: begin
          beat_ff <= beat_ff + 3'h1;
          if (beat_ff == LAST_BEAT) begin
            state_ff <= ST_IDLE;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  smb_burst_order u_order (
    .start_i(start_ff),
    .beat_i(beat_ff),
    .interleave_i(primary_mode_reg_ff[ORDER_BIT]),
    .write_i(is_wr_ff),
    .chop_i(chop_ff),
    .col_o(col)
  );

  assign mem_rd = mem[{base_ff, col}];

  always_comb begin
    if (!multi_purpose_readout_enable) begin
      rd_data = mem_rd;
    end else begin
      case (readout_location_select)
        LOC_PATTERN: rd_data = beat_ff[0] ? PAT_ONE : PAT_ZERO;
        LOC_TEMP: rd_data = temp_lnk_ff;
        default: rd_data = PAT_ZERO;
      endcase
    end
  end

  // write beats land in the array; chopped tail slots are not stored
  always_ff @(posedge ck_i) begin
    if (beat_live && is_wr_ff) begin
      mem[{base_ff, col}] <= dq_i;
    end
  end

  // read drive; chopped tail floats data and strobe
  always_ff @(posedge ck_i) begin
    if (lrst) begin
      dq_o <= PAT_ZERO;
      dq_oe_o <= 1'b0;
      dqs_o <= 1'b0;
      dqs_oe_o <= 1'b0;
    end else begin
      dq_o <= rd_data;
      dq_oe_o <= beat_live & ~is_wr_ff;
      dqs_o <= ~beat_ff[0];
      dqs_oe_o <= beat_live & ~is_wr_ff;
    end
  end

  // internal write start event, earlier only for fixed chop
  always_ff @(posedge ck_i) begin
    if (lrst) begin
      wr_tgl_ff <= 1'b0;
    end else if (in_burst && is_wr_ff
                 && beat_ff == (fixchop_ff ? WR_START_BC4 : WR_START_BL8)) begin
      wr_tgl_ff <= ~wr_tgl_ff;
    end
  end

  // temperature word handshake, link side
  smb_sync #(.W(1)) u_req (
    .clk_i(ck_i),
    .rst_i(lrst),
    .d_i(req_ff),
    .q_o(req_s)
  );

  always_ff @(posedge ck_i) begin
    if (lrst) begin
      temp_lnk_ff <= TEMP_RESET;
      ack_ff <= 1'b0;
    end else if (req_s != ack_ff) begin
      temp_lnk_ff <= temp_hold_ff;
      ack_ff <= req_s;
    end
  end

  // core side
  smb_sync #(.W(1)) u_ack (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(ack_ff),
    .q_o(ack_s)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_ff <= 1'b0;
      temp_hold_ff <= TEMP_RESET;
    end else if (ack_s == req_ff) begin
      temp_hold_ff <= temp_code_i;
      req_ff <= ~req_ff;
    end
  end

  smb_sync #(.W(1)) u_wrt (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(wr_tgl_ff),
    .q_o(wr_tgl_s)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_tgl_seen_ff <= 1'b0;
      int_write_start_o <= 1'b0;
    end else begin
      wr_tgl_seen_ff <= wr_tgl_s;
      int_write_start_o <= wr_tgl_s ^ wr_tgl_seen_ff;
    end
  end

  smb_sync #(.W(3)) u_stat (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({multi_purpose_readout_enable, readout_location_select}),
    .q_o(status_s)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_prev_ff <= 3'h0;
      readout_en_o <= 1'b0;
      readout_loc_o <= 2'h0;
    end else begin
      status_prev_ff <= status_s;
      // take the word only when two samples agree, so skewed bits never show
      if (status_s == status_prev_ff) begin
        readout_en_o <= status_s.ro_en;
        readout_loc_o <= status_s.loc;
      end
    end
  end

  property p_mrs_latch;
    @(posedge ck_i) disable iff (lrst)
      (state_ff == ST_IDLE && is_mrs && cmd_i.ba == BA_READOUT)
      |=> readout_control_mode_reg_ff == $past(cmd_i.addr);
  endproperty
  a_mrs_latch: assert property (p_mrs_latch) else $error("readout register not loaded");

  property p_pattern;
    @(posedge ck_i) disable iff (lrst)
      (beat_live && !is_wr_ff && multi_purpose_readout_enable
       && readout_location_select == LOC_PATTERN)
      |=> dq_oe_o && dq_o == ($past(beat_ff[0]) ? PAT_ONE : PAT_ZERO);
  endproperty
  a_pattern: assert property (p_pattern) else $error("training pattern wrong");

  property p_temp;
    @(posedge ck_i) disable iff (lrst)
      (beat_live && !is_wr_ff && multi_purpose_readout_enable
       && readout_location_select == LOC_TEMP)
      |=> dq_o == $past(temp_lnk_ff);
  endproperty
  a_temp: assert property (p_temp) else $error("temperature readout wrong");

  property p_normal;
    @(posedge ck_i) disable iff (lrst)
      (beat_live && !is_wr_ff && !multi_purpose_readout_enable)
      |=> dq_o == $past(mem_rd);
  endproperty
  a_normal: assert property (p_normal) else $error("array read overridden");

  property p_first_beat;
    @(posedge ck_i) disable iff (lrst)
      (in_burst && !is_wr_ff && beat_ff == 3'h0) |-> col == start_ff;
  endproperty
  a_first_beat: assert property (p_first_beat) else $error("burst start wrong");

  property p_interleave;
    @(posedge ck_i) disable iff (lrst)
      (in_burst && !is_wr_ff && primary_mode_reg_ff[ORDER_BIT]) |-> col == (start_ff ^ beat_ff);
  endproperty
  a_interleave: assert property (p_interleave) else $error("interleave order wrong");

  property p_nibble;
    @(posedge ck_i) disable iff (lrst)
      (in_burst && !is_wr_ff && !primary_mode_reg_ff[ORDER_BIT])
      |-> col[1:0] == 2'(start_ff[1:0] + beat_ff[1:0]) && col[2] == (start_ff[2] ^ beat_ff[2]);
  endproperty
  a_nibble: assert property (p_nibble) else $error("nibble order wrong");

  property p_write_order;
    @(posedge ck_i) disable iff (lrst)
      (in_burst && is_wr_ff)
      |-> col == (chop_ff ? {start_ff[2], beat_ff[1:0]} : beat_ff);
  endproperty
  a_write_order: assert property (p_write_order) else $error("write order wrong");

  property p_chop_float;
    @(posedge ck_i) disable iff (lrst)
      (in_burst && !is_wr_ff && chop_ff && beat_ff == 3'h4)
      |=> (!dq_oe_o && !dqs_oe_o) [*4];
  endproperty
  a_chop_float: assert property (p_chop_float) else $error("chopped tail driven");

  property p_fixed_early;
    @(posedge ck_i) disable iff (lrst)
      (in_burst && is_wr_ff && fixchop_ff && beat_ff == WR_START_BC4)
      |=> wr_tgl_ff != $past(wr_tgl_ff) ##1 $stable(wr_tgl_ff);
  endproperty
  a_fixed_early: assert property (p_fixed_early) else $error("early write start missing");

  property p_otf_late;
    @(posedge ck_i) disable iff (lrst)
      (in_burst && is_wr_ff && !fixchop_ff && beat_ff == WR_START_BC4)
      |=> $stable(wr_tgl_ff) ##1 $stable(wr_tgl_ff) ##1 $changed(wr_tgl_ff);
  endproperty
  a_otf_late: assert property (p_otf_late) else $error("write start not at length-8 time");
endmodule : smb_mr3_burst_top

// [include/smb_pkg.sv]
// What this block does
// - mode set: all four strobes low, bank 011 loads the readout control register
// - location bits 1:0 pick training pattern (00) or die temperature (11)
// - readout enable bit 2 set makes reads return the selected readout data
// - with readout disabled reads ignore the location bits; readout_loc_o still reports them
// - bit 3 of the primary register picks interleaved or nibble order
// - read bursts start at column bits 2:0 given with the command
// - interleaved reads deliver column start xor beat for beats 0..7
// - nibble reads wrap within start nibble, then the other nibble
// - length-8 writes ignore column bits 2:0 and fill columns 0..7
// - chopped writes: column bit 2 picks half, bits 1:0 ignored
// - chopped reads drive four beats then float data and strobe
// - fixed chop mode starts internal write two clocks earlier
// - on-the-fly chop starts internal write same as length 8
package smb_pkg;
  localparam logic [2:0] BA_PRIMARY = 3'h0;
  localparam logic [2:0] BA_READOUT = 3'h3;
  localparam int LOC_LSB = 0;
  localparam int RO_EN_BIT = 2;
  localparam int ORDER_BIT = 3;
  localparam int BL_LSB = 0;
  localparam int CHOP_PIN_BIT = 12;
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;
  localparam logic [1:0] LOC_PATTERN = 2'h0;
  localparam logic [1:0] LOC_TEMP = 2'h3;
  localparam logic [14:0] MR_RESET = 15'h0000;
  localparam logic [7:0] PAT_ONE = 8'hff;
  localparam logic [7:0] PAT_ZERO = 8'h00;
  localparam logic [7:0] TEMP_RESET = 8'h00;
  localparam logic [3:0] ACCESS_LAT = 4'h5;
  localparam logic [3:0] WAIT_LOAD = ACCESS_LAT - 4'h2;
  localparam logic [2:0] LAST_BEAT = 3'h7;
  localparam logic [2:0] EARLY_CLKS = 3'h2;
  localparam logic [2:0] WR_START_BL8 = LAST_BEAT;
  localparam logic [2:0] WR_START_BC4 = LAST_BEAT - EARLY_CLKS;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_BURST = 2'b11
  } smb_state_t;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [2:0] ba;
    logic [14:0] addr;
  } smb_cmd_t;

  typedef struct packed {
    logic ro_en;
    logic [1:0] loc;
  } smb_status_t;
endpackage : smb_pkg

// [design/smb_sync.sv]
`timescale 1ns/1ns
module smb_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  // one two-stage chain per bit
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        meta_ff[i] <= 1'b0;
        q_ff[i] <= 1'b0;
      end else begin
        meta_ff[i] <= d_i[i];
        q_ff[i] <= meta_ff[i];
      end
    end
  end

  assign q_o = q_ff;
endmodule : smb_sync

// [design/smb_burst_order.sv]
`timescale 1ns/1ns
module smb_burst_order (
  input wire logic [2:0] start_i,
  input wire logic [2:0] beat_i,
  input wire logic interleave_i,
  input wire logic write_i,
  input wire logic chop_i,
  output logic [2:0] col_o
);
  always_comb begin
    if (write_i) begin
      col_o = chop_i ? {start_i[2], beat_i[1:0]} : beat_i;
    end else if (interleave_i) begin
      col_o = start_i ^ beat_i;
    end else begin
      col_o = {start_i[2] ^ beat_i[2], 2'(start_i[1:0] + beat_i[1:0])};
    end
  end
endmodule : smb_burst_order

// [verif/smb_ctrl_model.sv]
`timescale 1ns/1ns
module smb_ctrl_model (
  input wire logic ck_i,
  input wire logic [7:0] rdata_i,
  input wire logic rd_oe_i,
  input wire logic strobe_i,
  input wire logic strobe_oe_i,
  output smb_pkg::smb_cmd_t cmd_o,
  output logic [7:0] wdata_o
);
  import smb_pkg::*;
  initial begin
    cmd_o = {1'b1, 3'h7, 3'h0, 15'h0000};
    wdata_o = 8'h00;
  end

  // one command cycle, then a deselected bus showing the inverse
  task automatic send(input logic [2:0] rcw, input logic [2:0] ba, input logic [14:0] a);
    @(negedge ck_i);
    cmd_o = {1'b0, rcw, ba, a};
    @(negedge ck_i);
    cmd_o = {1'b1, ~rcw, ~ba, ~a};
  endtask : send

  task automatic mr0(input logic il, input logic [1:0] bl);
    send(3'h0, BA_PRIMARY, {11'h000, il, 1'b0, bl});
  endtask : mr0

  task automatic mr3(input logic en, input logic [1:0] loc);
    send(3'h0, BA_READOUT, {12'h000, en, loc});
  endtask : mr3

  task automatic rd(input logic [14:0] a, output logic [63:0] d, output logic [7:0] oe,
                    output logic [7:0] s);
    int n;
    send(3'h5, 3'h0, a);
    for (n = 0; n < 12 && rd_oe_i !== 1'b1; n++) begin
      @(negedge ck_i);
    end
    for (n = 0; n < 8; n++) begin
      d[n*8+:8] = rdata_i;
      // data and strobe enables must agree; a split shows as unknown
      oe[n] = (rd_oe_i === strobe_oe_i) ? rd_oe_i : 1'bx;
      s[n] = strobe_i;
      @(negedge ck_i);
    end
    repeat (3) @(posedge ck_i);
  endtask : rd

  task automatic wr(input logic [14:0] a, input logic [63:0] d);
    int k;
    send(3'h4, 3'h0, a);
    repeat (3) @(negedge ck_i);
    for (k = 0; k < 8; k++) begin
      @(negedge ck_i);
      wdata_o = d[k*8+:8];
    end
    @(negedge ck_i);
    wdata_o = ~wdata_o;
  endtask : wr
endmodule : smb_ctrl_model

// [verif/smb_mr3_burst_top_test.sv]
`timescale 1ns/1ns
module smb_mr3_burst_top_test;
  import smb_pkg::*;
  logic clk_i = 1'b0;
  logic ck_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] temp_code_i = 8'h00;
  logic readout_en_o, int_write_start_o, dq_oe_o, dqs_o, dqs_oe_o;
  logic [1:0] readout_loc_o;
  logic [7:0] dq_o, dq_i;
  smb_cmd_t cmd_i;
  logic [7:0] mem [64];
  logic cur_il;
  int err_total = 0;
  int total_checks = 0;
  int seed = 38;
  int pulses = 0;
  int wr_cnt = 0;
  int g, st;

  always #50 clk_i = ~clk_i;
  always #3 ck_i = ~ck_i;
  always @(negedge clk_i) if (int_write_start_o === 1'b1) pulses++;

  smb_mr3_burst_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .temp_code_i(temp_code_i),
    .readout_en_o(readout_en_o), .readout_loc_o(readout_loc_o),
    .int_write_start_o(int_write_start_o), .ck_i(ck_i), .cmd_i(cmd_i), .dq_i(dq_i),
    .dq_o(dq_o), .dq_oe_o(dq_oe_o), .dqs_o(dqs_o), .dqs_oe_o(dqs_oe_o));
  smb_ctrl_model u_ctl (.ck_i(ck_i), .rdata_i(dq_o), .rd_oe_i(dq_oe_o), .strobe_i(dqs_o),
    .strobe_oe_i(dqs_oe_o), .cmd_o(cmd_i), .wdata_o(dq_i));

  function automatic logic [2:0] rd_col(input logic [2:0] s, input logic [2:0] k,
                                        input logic il);
    rd_col = il ? (s ^ k) : {s[2] ^ k[2], s[1:0] + k[1:0]};
  endfunction : rd_col

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk1

  task automatic do_wr(input logic [14:0] a, input logic chop);
    logic [63:0] d;
    int k;
    d = {$random(seed), $random(seed)};
    u_ctl.wr(a, d);
    for (k = 0; k < 8; k++) begin
      if (!chop) mem[{a[5:3], 3'(k)}] = d[k*8+:8];
      else if (k < 4) mem[{a[5:3], a[2], 2'(k)}] = d[k*8+:8];
    end
    wr_cnt++;
    repeat (90) @(posedge ck_i);
  endtask : do_wr

  // ro: 0 array, 1 training pattern, 2 temperature
  task automatic do_rd(input logic [14:0] a, input logic chop, input int ro);
    logic [63:0] d;
    logic [7:0] oe, s, e;
    int k;
    u_ctl.rd(a, d, oe, s);
    for (k = 0; k < 8; k++) begin
      e = (ro == 1) ? (k[0] ? PAT_ONE : PAT_ZERO) : (ro == 2) ? temp_code_i :
          mem[{a[5:3], rd_col(a[2:0], 3'(k), cur_il)}];
      if (k < 4 || !chop) begin
        chk8(d[k*8+:8], e);
        chk1(oe[k], 1'b1);
        chk1(s[k], ~k[0]);
      end else begin
        chk1(oe[k], 1'b0);
      end
    end
  endtask : do_rd

  task automatic set_mr0(input logic il, input logic [1:0] bl);
    cur_il = il;
    u_ctl.mr0(il, bl);
  endtask : set_mr0

  task automatic ro_set(input logic en, input logic [1:0] loc);
    u_ctl.mr3(en, loc);
    repeat (20) @(negedge clk_i);
    chk1(readout_en_o, en);
    if (en) chk8({6'h00, readout_loc_o}, {6'h00, loc});
  endtask : ro_set

  task automatic give_verdict;
    if (err_total == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict

  initial begin
    #200000;
    err_total++;
    give_verdict();
  end

  initial begin
    repeat (5) @(posedge clk_i);
    @(negedge clk_i) rst_i = 1'b0;
    repeat (4) @(posedge ck_i);
    set_mr0(1'b0, BL_FIXED8);
    for (g = 0; g < 8; g++) do_wr({9'h000, 3'(g), 3'($random(seed))}, 1'b0);
    for (g = 0; g < 2; g++) begin
      set_mr0(g[0], BL_FIXED8);
      for (st = 0; st < 8; st++) do_rd({9'h000, 3'($random(seed)), 3'(st)}, 1'b0, 0);
    end
    set_mr0(1'b1, BL_FIXED4);
    do_wr({9'h000, 3'h2, 1'b0, 2'($random(seed))}, 1'b1);
    do_wr({9'h000, 3'h5, 1'b1, 2'($random(seed))}, 1'b1);
    do_rd({9'h000, 3'h2, 3'($random(seed))}, 1'b1, 0);
    do_rd({9'h000, 3'h5, 3'($random(seed))}, 1'b1, 0);
    set_mr0(1'b0, BL_OTF);
    do_wr({9'h000, 3'h6, 1'b1, 2'h3}, 1'b1);
    do_rd({3'h0, 6'h00, 3'h6, 3'h5}, 1'b1, 0);
    do_rd({3'h1, 6'h00, 3'h6, 3'h3}, 1'b0, 0);
    set_mr0(1'b0, BL_FIXED8);
    @(negedge clk_i) temp_code_i = 8'($random(seed));
    ro_set(1'b1, LOC_PATTERN);
    do_rd({9'h000, 6'($random(seed))}, 1'b0, 1);
    ro_set(1'b1, LOC_TEMP);
    do_rd({9'h000, 6'($random(seed))}, 1'b0, 2);
    ro_set(1'b0, LOC_TEMP);
    do_rd({9'h000, 6'($random(seed))}, 1'b0, 0);
    chk8(8'(pulses), 8'(wr_cnt));
    give_verdict();
  end
endmodule : smb_mr3_burst_top_test
